// [design/mq_flags_pkg.sv]
// Constants shared by the multi-queue flag device and its controller.
// Assumes both ends run on one clock, mclk, with asynchronous active-low reset.
// What this block does
// - Width set-up picks x36/x18/x9 port widths
// - One full flag for selected write queue
// - Full flag shows new queue next edge
// - Write new queue from second edge on
// - Full flag changes only on clock edges
// - Full status kept per queue, reads change it
// - Full flag driven only when chip code matches
// - Controller shares full flag, one device written
// - Full flag tracks switches within own queues
// - Valid flag updates with output register load
// - After last word, valid goes high next read
// - New read queue word after two cycles
// - Empty status kept per queue, writes change it
// - Valid flag changes only on clock edges
// - Valid flag driven only when chip code matches
// - Controller shares valid flag, one device read
// - Width set-up sampled on first edge after master reset
// - Full counting in write-port-width units
// - Valid counting in read-port-width units
// - Narrow units packed little-endian in 36 bits
package mq_flags_pkg;
    localparam int queue_bits = 4;
    localparam int chip_bits = 3;
    localparam int addr_bits = queue_bits + chip_bits;
    localparam int word_bits = 36;
    localparam int queue_depth_words = 4;
    localparam int unit_count_bits = 6;
    // Width codes: units of 9 bits per port transfer
    localparam logic [2:0] units_x36 = 3'h4;
    localparam logic [2:0] units_x18 = 3'h2;
    localparam logic [2:0] units_x9 = 3'h1;
    localparam logic flag_reset_full_n = 1'h1;
    localparam logic flag_reset_valid_n = 1'h1;
    localparam int read_switch_cycles = 2;
    localparam int write_switch_cycles = 2;
endpackage

// [design/mq_flags_if.sv]
// Pin-level carrier joining the flag device and the system controller.
// Assumes the testbench resolves the shared flags from the enables.
`timescale 1ns/100ps
interface mq_flags_if;
    import mq_flags_pkg::*;
    logic [addr_bits-1:0] write_queue_select_bus;
    logic write_select_strobe;
    logic write_enable_n;
    logic [word_bits-1:0] write_data;
    logic [addr_bits-1:0] read_queue_select_bus;
    logic read_select_strobe;
    logic read_enable_n;
    logic [word_bits-1:0] read_data;
    logic active_queue_full_flag_o;
    logic active_queue_full_flag_oe_n;
    logic output_word_valid_n_o;
    logic output_word_valid_n_oe_n;
    logic active_queue_full_flag;
    logic output_word_valid_n;
    modport device (
        input write_queue_select_bus, write_select_strobe, write_enable_n, write_data,
        input read_queue_select_bus, read_select_strobe, read_enable_n,
        output read_data, active_queue_full_flag_o, active_queue_full_flag_oe_n,
        output output_word_valid_n_o, output_word_valid_n_oe_n
    );
    modport controller (
        output write_queue_select_bus, write_select_strobe, write_enable_n, write_data,
        output read_queue_select_bus, read_select_strobe, read_enable_n,
        input read_data, active_queue_full_flag, output_word_valid_n
    );
endinterface

// [design/mq_flags_device.sv]
// Device end: per-queue storage with active-queue full and output-valid flags.
// Assumes one clock for both ports and a controller that keeps the switch timing.
`timescale 1ns/100ps
module mq_flags_device
    import mq_flags_pkg::*;
#(
    parameter int depth_words = queue_depth_words
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic width_match_enable,
    input wire logic input_width_select,
    input wire logic output_width_select,
    input wire logic chip_select_code_bit0,
    input wire logic chip_select_code_bit1,
    input wire logic chip_select_code_bit2,
    mq_flags_if.device link
);
    localparam int nq = 1 << queue_bits;
    localparam int cap_units = depth_words * 4;
    localparam int mem_units = nq * cap_units;
    localparam int ptr_bits = $clog2(cap_units);

    // ************************************************************
    // Set-up capture
    // ************************************************************
    logic [2:0] win_units_reg;
    logic [2:0] rout_units_reg;
    logic [2:0] win_units_next;
    logic [2:0] rout_units_next;
    logic in_reset_reg;
    logic [chip_bits-1:0] chip_code;

    assign chip_code = {chip_select_code_bit2, chip_select_code_bit1, chip_select_code_bit0};

    // Width decode from the set-up pins
    always_comb begin
        win_units_next = units_x36;
        rout_units_next = units_x36;
        if (width_match_enable) begin
            if (!input_width_select && !output_width_select) begin
                rout_units_next = units_x18;
            end else if (!input_width_select) begin
                rout_units_next = units_x9;
            end else if (!output_width_select) begin
                win_units_next = units_x18;
            end else begin
                win_units_next = units_x9;
            end
        end
    end

    // Pins are caught on the first edge after release, straps held static
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            in_reset_reg <= 1'b1;
            win_units_reg <= units_x36;
            rout_units_reg <= units_x36;
        end else if (in_reset_reg) begin
            in_reset_reg <= 1'b0;
            win_units_reg <= win_units_next;
            rout_units_reg <= rout_units_next;
        end
    end

    // ************************************************************
    // Storage in 9-bit units, per-queue occupancy
    // ************************************************************
    logic [8:0] mem [mem_units];
    logic [ptr_bits-1:0] wptr_reg [nq];
    logic [ptr_bits-1:0] rptr_reg [nq];
    logic [unit_count_bits-1:0] fill_reg [nq];
    logic [queue_bits-1:0] wq_reg;
    logic [queue_bits-1:0] rq_reg;
    logic w_mine_reg;
    logic r_mine_reg;
    logic do_write;
    logic do_read;

    // Queue selection on the strobe edge
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wq_reg <= '0;
            rq_reg <= '0;
            w_mine_reg <= 1'b0;
            r_mine_reg <= 1'b0;
        end else begin
            if (link.write_select_strobe) begin
                wq_reg <= link.write_queue_select_bus[queue_bits-1:0];
                w_mine_reg <= link.write_queue_select_bus[addr_bits-1:queue_bits] == chip_code;
            end
            if (link.read_select_strobe) begin
                rq_reg <= link.read_queue_select_bus[queue_bits-1:0];
                r_mine_reg <= link.read_queue_select_bus[addr_bits-1:queue_bits] == chip_code;
            end
        end
    end

    // Occupancy in units: room counted per write width, data per read width
    logic w_room;
    logic r_avail;
    logic [unit_count_bits-1:0] wfill;
    assign wfill = fill_reg[wq_reg];
    assign w_room = 32'(wfill) + 32'(win_units_reg) <= cap_units;
    assign r_avail = 32'(fill_reg[rq_reg]) >= 32'(rout_units_reg);
    assign do_write = w_mine_reg && !link.write_enable_n && w_room && !in_reset_reg;
    logic out_empty;
    logic load_out;
    assign do_read = r_mine_reg && r_avail && load_out && !in_reset_reg;

    // Per-queue pointers and fill; a write to the read queue adds in the same edge
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int q = 0; q < nq; q++) begin
                wptr_reg[q] <= '0;
                rptr_reg[q] <= '0;
                fill_reg[q] <= '0;
            end
        end else begin
            for (int q = 0; q < nq; q++) begin
                logic [unit_count_bits-1:0] f;
                f = fill_reg[q];
                if (do_write && wq_reg == queue_bits'(q)) begin
                    f = f + unit_count_bits'(win_units_reg);
                    wptr_reg[q] <= ptr_bits'(wptr_reg[q] + ptr_bits'(win_units_reg));
                end
                if (do_read && rq_reg == queue_bits'(q)) begin
                    f = f - unit_count_bits'(rout_units_reg);
                    rptr_reg[q] <= ptr_bits'(rptr_reg[q] + ptr_bits'(rout_units_reg));
                end
                fill_reg[q] <= f;
            end
        end
    end

    // Little-endian unit placement, lowest byte first
    always_ff @(posedge mclk) begin
        if (do_write) begin
            for (int u = 0; u < 4; u++) begin
                if (u < int'(win_units_reg)) begin
                    mem[int'(wq_reg) * cap_units + int'(wptr_reg[wq_reg]) + u] <= link.write_data[u*9 +: 9];
                end
            end
        end
    end

    // ************************************************************
    // Read pipeline and output register
    // ************************************************************
    logic [1:0] switch_cnt_reg;
    logic [word_bits-1:0] rdata_reg;
    logic valid_n_reg;

    // Two-cycle read switch: old data holds until the new queue word lands
    // The count reaches one on the edge before the one that loads from the new queue
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            switch_cnt_reg <= '0;
        end else if (link.read_select_strobe) begin
            switch_cnt_reg <= 2'(read_switch_cycles);
        end else if (switch_cnt_reg != 2'h0) begin
            switch_cnt_reg <= switch_cnt_reg - 2'h1;
        end
    end

    // Second edge after a switch loads unless a new select strobe comes on it, so the new queue shows on time;
    // an unread word of the old queue is dropped there, which the user must allow for
    logic switch_load;
    assign switch_load = switch_cnt_reg == 2'h1;
    assign out_empty = valid_n_reg;
    // Otherwise load when output empty (fall-through) or on an enabled read
    assign load_out = !link.read_select_strobe &&
        (switch_load || (switch_cnt_reg == 2'h0 && (out_empty || !link.read_enable_n)));

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= '0;
            valid_n_reg <= flag_reset_valid_n;
        end else if (load_out) begin
            if (do_read) begin
                for (int u = 0; u < 4; u++) begin
                    rdata_reg[u*9 +: 9] <= u < int'(rout_units_reg) ?
                        mem[int'(rq_reg) * cap_units + int'(rptr_reg[rq_reg]) + u] : 9'h000;
                end
                valid_n_reg <= 1'b0;
            end else begin
                valid_n_reg <= 1'b1;
            end
        end
    end

    // Full flag registered every edge, from the select bus on the selection edge
    logic full_n_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            full_n_reg <= flag_reset_full_n;
        end else begin
            full_n_reg <= !(32'(fill_reg[link.write_select_strobe ? link.write_queue_select_bus[queue_bits-1:0] :
                wq_reg]) + 32'(win_units_reg) > cap_units);
        end
    end

    // Shared flags: enables low only while this chip is addressed
    assign link.active_queue_full_flag_o = full_n_reg;
    assign link.active_queue_full_flag_oe_n = !w_mine_reg;
    assign link.output_word_valid_n_o = valid_n_reg;
    assign link.output_word_valid_n_oe_n = !r_mine_reg;
    assign link.read_data = rdata_reg;
endmodule

// [design/mq_flags_controller.sv]
// Controller end: selects queues, honours the switch delay and the shared flags.
// Assumes a user side issuing one write and one read request at a time.
`timescale 1ns/100ps
module mq_flags_controller
    import mq_flags_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic wr_req,
    input wire logic [addr_bits-1:0] wr_addr,
    input wire logic [word_bits-1:0] wr_data,
    output logic wr_busy,
    input wire logic rd_sel_req,
    input wire logic [addr_bits-1:0] rd_addr,
    input wire logic rd_take,
    output logic [word_bits-1:0] rd_data,
    output logic rd_valid,
    mq_flags_if.controller link
);
    logic [addr_bits-1:0] cur_waddr_reg;
    logic [1:0] wwait_reg;
    logic sel_now;
    logic [word_bits-1:0] wdata_reg;
    logic wen_n_reg;

    // A new queue costs a select edge plus one warning cycle
    assign sel_now = wr_req && wr_addr != cur_waddr_reg && wwait_reg == 2'h0;
    assign wr_busy = wwait_reg != 2'h0 || sel_now || link.active_queue_full_flag == 1'b0;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cur_waddr_reg <= '0;
            wwait_reg <= '0;
            wdata_reg <= '0;
            wen_n_reg <= 1'b1;
        end else begin
            wen_n_reg <= 1'b1;
            if (sel_now) begin
                cur_waddr_reg <= wr_addr;
                wwait_reg <= 2'(write_switch_cycles - 1);
            end else if (wwait_reg != 2'h0) begin
                wwait_reg <= wwait_reg - 2'h1;
            end else if (wr_req && link.active_queue_full_flag) begin
                wdata_reg <= wr_data;
                wen_n_reg <= 1'b0;
            end
        end
    end

    assign link.write_queue_select_bus = sel_now ? wr_addr : cur_waddr_reg;
    assign link.write_select_strobe = sel_now;
    assign link.write_enable_n = wen_n_reg;
    assign link.write_data = wdata_reg;

    // Read side: one device addressed at a time, valid taken from the shared flag
    logic [addr_bits-1:0] cur_raddr_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cur_raddr_reg <= '0;
        end else if (rd_sel_req) begin
            cur_raddr_reg <= rd_addr;
        end
    end

    assign link.read_queue_select_bus = rd_sel_req ? rd_addr : cur_raddr_reg;
    assign link.read_select_strobe = rd_sel_req;
    assign link.read_enable_n = !(rd_take && !link.output_word_valid_n);
    assign rd_data = link.read_data;
    assign rd_valid = !link.output_word_valid_n;
endmodule

// [dv/mq_flags_properties.sv]
// Checker on the carrier signals between flag device and controller.
// Assumes instantiation beside the carrier with every signal wired by name.
`timescale 1ns/100ps
module mq_flags_properties
    import mq_flags_pkg::*;
#(
    parameter logic [2:0] chip_code = 3'h5
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [addr_bits-1:0] write_queue_select_bus,
    input wire logic write_select_strobe,
    input wire logic write_enable_n,
    input wire logic [addr_bits-1:0] read_queue_select_bus,
    input wire logic read_select_strobe,
    input wire logic read_enable_n,
    input wire logic [word_bits-1:0] read_data,
    input wire logic active_queue_full_flag_o,
    input wire logic active_queue_full_flag_oe_n,
    input wire logic output_word_valid_n_o,
    input wire logic output_word_valid_n_oe_n
);
    // ************************************
    // Flag timing and tri-state checks
    // ************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_full_drive;
        write_select_strobe && write_queue_select_bus[addr_bits-1:queue_bits] == chip_code
            |=> !active_queue_full_flag_oe_n;
    endproperty
    a_full_drive: assert property (p_full_drive) else $error("full flag not driven for own chip");
    property p_full_hiz;
        write_select_strobe && write_queue_select_bus[addr_bits-1:queue_bits] != chip_code
            |=> active_queue_full_flag_oe_n;
    endproperty
    a_full_hiz: assert property (p_full_hiz) else $error("full flag driven for other chip");
    property p_valid_drive;
        read_select_strobe && read_queue_select_bus[addr_bits-1:queue_bits] == chip_code
            |-> ##[1:2] !output_word_valid_n_oe_n;
    endproperty
    a_valid_drive: assert property (p_valid_drive) else $error("valid flag not driven for own chip");
    property p_valid_hiz;
        read_select_strobe && read_queue_select_bus[addr_bits-1:queue_bits] != chip_code
            |-> ##[1:2] output_word_valid_n_oe_n;
    endproperty
    a_valid_hiz: assert property (p_valid_hiz) else $error("valid flag driven for other chip");
    // Controller must leave one warning cycle after a write select
    property p_no_early_write;
        write_select_strobe |=> write_enable_n;
    endproperty
    a_no_early_write: assert property (p_no_early_write) else $error("write one edge after select");
    property p_switch_holds_old;
        read_select_strobe && read_enable_n && $past(read_enable_n)
            |=> $stable(read_data) && $stable(output_word_valid_n_o);
    endproperty
    a_switch_holds_old: assert property (p_switch_holds_old) else $error("old word lost after switch");
    // Excludes recent reads and switches, whose loads land later
    property p_valid_word_holds;
        !output_word_valid_n_o && read_enable_n && $past(read_enable_n) && !read_select_strobe
            && !$past(read_select_strobe) && !$past(read_select_strobe, 2) |=> $stable(read_data);
    endproperty
    a_valid_word_holds: assert property (p_valid_word_holds) else $error("valid word changed");
    property p_reset_flags;
        $rose(rstn) |-> active_queue_full_flag_o && output_word_valid_n_o;
    endproperty
    a_reset_flags: assert property (p_reset_flags) else $error("flags not inactive after reset");
endmodule

// [dv/multiqueue_full_valid_flags_test.sv]
// Testbench joining flag device and controller across the carrier.
// Assumes the controller user side takes one request at a time.
`timescale 1ns/100ps
module multiqueue_full_valid_flags_test;
    import mq_flags_pkg::*;
    // ************************************
    // Clock, reset, instances
    // ************************************
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic width_match_enable = 1'b0;
    logic input_width_select = 1'b0;
    logic output_width_select = 1'b0;
    logic [2:0] chip_code = 3'h5;
    logic wr_req = 1'b0;
    logic [addr_bits-1:0] wr_addr = '0;
    logic [word_bits-1:0] wr_data = '0;
    logic wr_busy;
    logic rd_sel_req = 1'b0;
    logic [addr_bits-1:0] rd_addr = '0;
    logic rd_take = 1'b0;
    logic [word_bits-1:0] rd_data;
    logic rd_valid;
    int miscompares = 0;
    int comparisons = 0;
    always #50 mclk = ~mclk;
    mq_flags_if link();
    // Pull-ups on the shared flags when no device drives them
    assign link.active_queue_full_flag = link.active_queue_full_flag_oe_n ? 1'b1 : link.active_queue_full_flag_o;
    assign link.output_word_valid_n = link.output_word_valid_n_oe_n ? 1'b1 : link.output_word_valid_n_o;
    mq_flags_device mq_flags_device_i (.mclk(mclk), .rstn(rstn), .width_match_enable(width_match_enable),
        .input_width_select(input_width_select), .output_width_select(output_width_select),
        .chip_select_code_bit0(chip_code[0]), .chip_select_code_bit1(chip_code[1]),
        .chip_select_code_bit2(chip_code[2]), .link(link));
    mq_flags_controller mq_flags_controller_i (.mclk(mclk), .rstn(rstn), .wr_req(wr_req), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_busy(wr_busy), .rd_sel_req(rd_sel_req), .rd_addr(rd_addr), .rd_take(rd_take),
        .rd_data(rd_data), .rd_valid(rd_valid), .link(link));
    mq_flags_properties mq_flags_properties_i (.mclk(mclk), .rstn(rstn),
        .write_queue_select_bus(link.write_queue_select_bus), .write_select_strobe(link.write_select_strobe),
        .write_enable_n(link.write_enable_n), .read_queue_select_bus(link.read_queue_select_bus),
        .read_select_strobe(link.read_select_strobe), .read_enable_n(link.read_enable_n),
        .read_data(link.read_data), .active_queue_full_flag_o(link.active_queue_full_flag_o),
        .active_queue_full_flag_oe_n(link.active_queue_full_flag_oe_n),
        .output_word_valid_n_o(link.output_word_valid_n_o), .output_word_valid_n_oe_n(link.output_word_valid_n_oe_n));
    // ************************************
    // Tasks
    // ************************************
    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Busy is combinational, so it is looked at just after the request settles
    task automatic wr(input logic [6:0] addr, input logic [35:0] data);
        int n;
        @(negedge mclk);
        wr_req = 1'b1;
        wr_addr = addr;
        wr_data = data;
        #1;
        n = 0;
        while (wr_busy !== 1'b0 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        wr_req = 1'b0;
        repeat (4) @(negedge mclk);
    endtask
    task automatic wait_flag(input bit valid_side, input logic exp);
        int n;
        n = 0;
        while ((valid_side ? link.output_word_valid_n : link.active_queue_full_flag) !== exp && n < 12) begin
            @(negedge mclk);
            n++;
        end
        check(valid_side ? "valid flag" : "full flag",
            valid_side ? link.output_word_valid_n : link.active_queue_full_flag, exp);
    endtask
    task automatic wait_word(input logic [35:0] exp);
        int n;
        n = 0;
        while ((link.read_data !== exp || link.output_word_valid_n !== 1'b0) && n < 12) begin
            @(negedge mclk);
            n++;
        end
        check("read word", link.read_data, exp);
        check("valid flag", link.output_word_valid_n, 0);
        check("user word", rd_data, exp);
        check("user valid", rd_valid, 1);
    endtask
    task automatic take();
        @(negedge mclk);
        rd_take = 1'b1;
        @(negedge mclk);
        rd_take = 1'b0;
    endtask
    // Old status after the first edge, new word and status after the second
    task automatic rd_sel(input logic [6:0] addr, input logic [35:0] exp, input logic old_n, input logic new_n);
        @(negedge mclk);
        rd_sel_req = 1'b1;
        rd_addr = addr;
        @(negedge mclk);
        rd_sel_req = 1'b0;
        @(negedge mclk);
        check("valid before switch", link.output_word_valid_n, old_n);
        @(negedge mclk);
        check("valid after switch", link.output_word_valid_n, new_n);
        if (new_n == 1'b0) begin
            check("first word", link.read_data, exp);
        end
    endtask
    // ************************************
    // Watchdog and main sequence
    // ************************************
    initial begin
        #300000;
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (3) @(negedge mclk);
        rstn = 1'b1;
        repeat (2) @(negedge mclk);
        wr({3'h2, 4'h1}, 36'h11);
        check("full oe", link.active_queue_full_flag_oe_n, 1);
        check("full flag", link.active_queue_full_flag, 1);
        for (int i = 0; i < 4; i++) begin
            wr({chip_code, 4'h2}, 36'hB0 + i);
        end
        wait_flag(0, 1'b0);
        check("busy when full", wr_busy, 1);
        check("full oe", link.active_queue_full_flag_oe_n, 0);
        fork
            wr({chip_code, 4'h1}, 36'hA0);
            begin
                @(posedge mclk iff link.write_select_strobe === 1'b1);
                repeat (2) @(negedge mclk);
                check("full after switch", link.active_queue_full_flag, 1);
            end
        join
        rd_sel({chip_code, 4'h2}, 36'hB0, 1'b1, 1'b0);
        take();
        wait_word(36'hB1);
        take();
        wait_word(36'hB2);
        wr({chip_code, 4'h2}, 36'hC0);
        wait_flag(0, 1'b1);
        rd_sel({chip_code, 4'h1}, 36'hA0, 1'b0, 1'b0);
        take();
        wait_flag(1, 1'b1);
        rd_sel({chip_code, 4'h3}, 36'h0, 1'b1, 1'b1);
        wr({chip_code, 4'h3}, 36'hD0);
        wait_word(36'hD0);
        rd_sel({3'h2, 4'h0}, 36'h0, 1'b1, 1'b1);
        check("valid oe", link.output_word_valid_n_oe_n, 1);
        // Second reset: x18 in, x36 out
        @(negedge mclk);
        rstn = 1'b0;
        width_match_enable = 1'b1;
        input_width_select = 1'b1;
        output_width_select = 1'b0;
        repeat (3) @(negedge mclk);
        rstn = 1'b1;
        repeat (2) @(negedge mclk);
        rd_sel({chip_code, 4'h0}, 36'h0, 1'b1, 1'b1);
        wr({chip_code, 4'h0}, 36'h12345);
        repeat (6) @(negedge mclk);
        check("valid after half word", link.output_word_valid_n, 1);
        wr({chip_code, 4'h0}, 36'h26789);
        wait_word({18'h26789, 18'h12345});
        give_verdict();
    end
endmodule
